// file: hdl/scmc_pkg.sv
// constants, types and decode helpers for the system clock mode control
package scmc_pkg;

    // --------------------------------------------------------------
    // oscillator and reference clock rates
    // --------------------------------------------------------------
    localparam int MCLK_HZ       = 10_000_000;
    localparam int FAST_OSC_HZ   = 8_000_000;  // fixed nominal rate
    localparam int SLOW_OSC_HZ   = 32_000;     // typical rate

    // --------------------------------------------------------------
    // select field and divider layout
    // --------------------------------------------------------------
    localparam int          SEL_W        = 3;
    localparam int          DIV_STAGES   = 6;  // divide by 2**6 = 64
    localparam logic [2:0]  SEL_SLOW     = 3'h7;
    localparam logic [2:0]  SEL_RESET    = 3'h0;
    localparam logic [2:0]  SW_CUR_TICKS = 3'h4;
    localparam logic [2:0]  CNT_ZERO     = 3'h0;
    localparam logic [2:0]  CNT_ONE      = 3'h1;

    // --------------------------------------------------------------
    // operating modes, gray coded along the usual path
    // --------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_FAST  = 3'h0,
        MODE_SLOW  = 3'h1,
        MODE_IDLE0 = 3'h3,
        MODE_IDLE1 = 3'h2,
        MODE_IDLE2 = 3'h6,
        MODE_SLEEP = 3'h7
    } scmc_mode_t;

    // clock switch sequencer
    typedef enum logic [1:0]
    {
        SW_STEADY = 2'h0,
        SW_WAIT   = 2'h1,
        SW_ALIGN  = 2'h3
    } scmc_sw_t;

    // select code 111 picks the sub clock
    function automatic logic scmc_is_slow(input logic [2:0] sel);
        return sel == SEL_SLOW;
    endfunction

    // modes in which the cpu executes
    function automatic logic scmc_is_run(input scmc_mode_t m);
        return (m == MODE_FAST) || (m == MODE_SLOW);
    endfunction

endpackage

// file: hdl/scmc_fast_div.sv
// ripple-free prescaler giving fast clock divided by 1 to 64 as ticks
`timescale 1ns/1ps
module scmc_fast_div
    import scmc_pkg::*;
#(
    parameter int STAGES = DIV_STAGES
)
(
    // clock and reset
    input  wire logic              MCLK,
    input  wire logic              RESETN,
    input  wire logic              CE,
    // fast oscillator tick in, divided ticks out
    input  wire logic              FAST_TICK,
    output logic [STAGES:0]        DIV_TICK
);

    // --------------------------------------------------------------
    // prescale counter
    // --------------------------------------------------------------
    logic [STAGES-1:0] cnt;
    logic [STAGES-1:0] next_cnt;

    // counts only on fast ticks, so taps stay phase locked
    always_comb
    begin
        next_cnt = cnt;
        if (FAST_TICK)
            next_cnt = cnt + 1'b1;
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            cnt <= '0;
        else if (CE)
            cnt <= next_cnt;
    end

    // --------------------------------------------------------------
    // taps: tap k fires once every 2**k fast ticks
    // --------------------------------------------------------------
    assign DIV_TICK[0] = FAST_TICK;
    genvar k;
    generate
        for (k = 1; k <= STAGES; k++)
        begin : g_tap
            assign DIV_TICK[k] = FAST_TICK & (&cnt[k-1:0]);
        end
    endgenerate

endmodule

// file: hdl/scmc_top.sv
// system clock source selection and halt-time power mode control
// The analog oscillators are outside; they hand in one-cycle ticks
// (synchronous to MCLK) and this block hands out gated clock ticks.
`timescale 1ns/1ps
module scmc_top
    import scmc_pkg::*;
(
    // clock, reset, freeze
    input  wire logic              MCLK,
    input  wire logic              RESETN,
    input  wire logic              CE,
    // control bits from software
    input  wire logic [SEL_W-1:0]  SYSCLK_SELECT,
    input  wire logic              HALT_FAST_OSC_KEEP,
    input  wire logic              HALT_SLOW_OSC_KEEP,
    input  wire logic              FAST_OSC_ENABLE,
    input  wire logic              WATCHDOG_TIMER_ENABLE,
    // cpu events
    input  wire logic              HALT_REQ,
    input  wire logic              WAKE_REQ,
    // oscillator ticks
    input  wire logic              FAST_OSC_TICK,
    input  wire logic              SLOW_OSC_TICK,
    // oscillator enables
    output logic                   FAST_OSC_RUN,
    output logic                   SLOW_OSC_RUN,
    // clock ticks out
    output logic                   SYS_TICK,
    output logic [DIV_STAGES:0]    FAST_DIV_TICK,
    output logic                   SUB_CLK_TICK,
    output logic                   SLOW_RC_OSC_TICK,
    // status
    output logic                   CPU_RUN,
    output scmc_mode_t             MODE,
    output logic [SEL_W-1:0]       ACTIVE_SELECT,
    output logic                   SWITCH_BUSY
);

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    scmc_mode_t         mode;
    scmc_mode_t         next_mode;
    scmc_sw_t           sw;
    scmc_sw_t           next_sw;
    logic [SEL_W-1:0]   active_sel;
    logic [SEL_W-1:0]   next_active_sel;
    logic [SEL_W-1:0]   pending_sel;
    logic [SEL_W-1:0]   next_pending_sel;
    logic [2:0]         sw_cnt;
    logic [2:0]         next_sw_cnt;
    logic               fast_run;
    logic               slow_run;
    logic               sub_on;
    logic               src_on;
    logic               sub_src;
    logic               cur_tick;
    logic               tgt_tick;
    logic               sys_pulse;
    logic [DIV_STAGES:0] taps;

    // --------------------------------------------------------------
    // fast clock prescaler
    // --------------------------------------------------------------
    scmc_fast_div #(.STAGES(DIV_STAGES)) u_div
    (
        .MCLK      (MCLK),
        .RESETN    (RESETN),
        .CE        (CE),
        .FAST_TICK (FAST_OSC_TICK & FAST_OSC_RUN),
        .DIV_TICK  (taps)
    );

    // tick of the source picked by a select code
    function automatic logic src_tick(input logic [2:0] sel);
        if (scmc_is_slow(sel))
            return sub_src;
        return taps[sel];
    endfunction

    // --------------------------------------------------------------
    // clock gating by mode
    // --------------------------------------------------------------
    always_comb
    begin
        sub_src  = SLOW_OSC_TICK & SLOW_OSC_RUN;
        sub_on   = 1'b1;
        src_on   = 1'b1;
        fast_run = 1'b1;
        slow_run = 1'b1;
        unique case (mode)
            MODE_FAST:  ;
            // fast kept while a switch still needs it
            MODE_SLOW:  fast_run = FAST_OSC_ENABLE
                            | (sw != SW_STEADY
                               && !scmc_is_slow(pending_sel));
            MODE_IDLE0:
            begin
                fast_run = 1'b0;
                src_on   = scmc_is_slow(active_sel);
            end
            MODE_IDLE1: ;
            MODE_IDLE2:
            begin
                sub_on = 1'b0;
                src_on = !scmc_is_slow(active_sel);
            end
            MODE_SLEEP:
            begin
                fast_run = 1'b0;
                sub_on   = 1'b0;
                src_on   = 1'b0;
                slow_run = WATCHDOG_TIMER_ENABLE;
            end
            default:
            begin
                fast_run = 1'b0;
                sub_on   = 1'b0;
                src_on   = 1'b0;
            end
        endcase
        cur_tick  = src_tick(active_sel) & src_on;
        tgt_tick  = src_tick(pending_sel);
        // the aligning gap swallows current ticks up to the target's first tick
        sys_pulse = cur_tick & (sw != SW_ALIGN);
    end

    // --------------------------------------------------------------
    // mode and clock switch control, next state
    // --------------------------------------------------------------
    always_comb
    begin
        next_mode        = mode;
        next_sw          = sw;
        next_active_sel  = active_sel;
        next_pending_sel = pending_sel;
        next_sw_cnt      = sw_cnt;
        // switch sequencer: count current ticks, then align
        unique case (sw)
            SW_STEADY:
                if (SYSCLK_SELECT != active_sel)
                begin
                    next_pending_sel = SYSCLK_SELECT;
                    next_sw_cnt      = CNT_ZERO;
                    next_sw          = SW_WAIT;
                end
            SW_WAIT:
            begin
                next_pending_sel = SYSCLK_SELECT;
                if (SYSCLK_SELECT == active_sel)
                    next_sw = SW_STEADY;
                else if (cur_tick)
                begin
                    next_sw_cnt = sw_cnt + CNT_ONE;
                    // the first tick only marks an edge, so the
                    // fifth one closes four whole current periods
                    if (sw_cnt == SW_CUR_TICKS)
                        next_sw = SW_ALIGN;
                end
            end
            SW_ALIGN:
                // hand over on a target edge, never mid period
                if (tgt_tick)
                begin
                    next_active_sel = pending_sel;
                    next_sw         = SW_STEADY;
                end
            default:
                next_sw = SW_STEADY;
        endcase
        // operating mode
        if (scmc_is_run(mode))
        begin
            if (HALT_REQ)
                unique case ({HALT_FAST_OSC_KEEP, HALT_SLOW_OSC_KEEP})
                    2'b00: next_mode = MODE_SLEEP;
                    2'b01: next_mode = MODE_IDLE0;
                    2'b11: next_mode = MODE_IDLE1;
                    2'b10: next_mode = MODE_IDLE2;
                endcase
            else if (scmc_is_slow(next_active_sel))
                next_mode = MODE_SLOW;
            else
                next_mode = MODE_FAST;
        end
        else if (WAKE_REQ)
            next_mode = scmc_is_slow(active_sel) ? MODE_SLOW
                                                 : MODE_FAST;
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mode        <= MODE_FAST;
            sw          <= SW_STEADY;
            active_sel  <= SEL_RESET;
            pending_sel <= SEL_RESET;
            sw_cnt      <= CNT_ZERO;
        end
        else if (CE)
        begin
            mode        <= next_mode;
            sw          <= next_sw;
            active_sel  <= next_active_sel;
            pending_sel <= next_pending_sel;
            sw_cnt      <= next_sw_cnt;
        end
    end

    // --------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            FAST_OSC_RUN  <= 1'b1;
            SLOW_OSC_RUN  <= 1'b1;
            SYS_TICK      <= 1'b0;
            FAST_DIV_TICK <= '0;
            SUB_CLK_TICK  <= 1'b0;
            SLOW_RC_OSC_TICK <= 1'b0;
            CPU_RUN       <= 1'b1;
            MODE          <= MODE_FAST;
            ACTIVE_SELECT <= SEL_RESET;
            SWITCH_BUSY   <= 1'b0;
        end
        else if (CE)
        begin
            FAST_OSC_RUN  <= fast_run;
            SLOW_OSC_RUN  <= slow_run;
            SYS_TICK      <= sys_pulse;
            FAST_DIV_TICK <= taps;
            SUB_CLK_TICK  <= sub_src & sub_on;
            SLOW_RC_OSC_TICK <= sub_src;
            CPU_RUN       <= scmc_is_run(mode);
            MODE          <= mode;
            ACTIVE_SELECT <= active_sel;
            SWITCH_BUSY   <= (sw != SW_STEADY);
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    logic [3:0] seen;  // current ticks seen since a switch began
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            seen <= '0;
        else if (CE)
            seen <= (sw == SW_STEADY) ? '0
                  : seen + {3'h0, cur_tick & (seen != 4'hF)};
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    sequence s_halt;
        CE && scmc_is_run(mode) && HALT_REQ;
    endsequence

    sequence s_sel_change;
        CE && sw == SW_STEADY && SYSCLK_SELECT != active_sel;
    endsequence

    a_halt_sleep: assert property (
        s_halt and (!HALT_FAST_OSC_KEEP && !HALT_SLOW_OSC_KEEP)
        |=> mode == MODE_SLEEP ##1 (!FAST_OSC_RUN || !CE))
        else $error("halt with no keep bits did not sleep");
    a_halt_idle0: assert property (
        s_halt and (!HALT_FAST_OSC_KEEP && HALT_SLOW_OSC_KEEP)
        |=> mode == MODE_IDLE0)
        else $error("halt with slow keep did not reach idle0");
    a_halt_idle1: assert property (
        s_halt and (HALT_FAST_OSC_KEEP && HALT_SLOW_OSC_KEEP)
        |=> mode == MODE_IDLE1)
        else $error("halt with both keeps did not reach idle1");
    a_halt_idle2: assert property (
        s_halt and (HALT_FAST_OSC_KEEP && !HALT_SLOW_OSC_KEEP)
        |=> mode == MODE_IDLE2)
        else $error("halt with fast keep did not reach idle2");
    a_sleep_slow_osc: assert property (
        (CE && mode == MODE_SLEEP)
        |=> SLOW_OSC_RUN == $past(WATCHDOG_TIMER_ENABLE) && !SUB_CLK_TICK)
        else $error("slow oscillator wrong in sleep");
    a_idle2_sub: assert property (
        (CE && mode == MODE_IDLE2) |=> !SUB_CLK_TICK && FAST_OSC_RUN)
        else $error("idle2 clocks wrong");
    a_switch_hold: assert property (
        s_sel_change |=> sw == SW_WAIT
                         && active_sel == $past(active_sel))
        else $error("select took effect without delay");
    a_four_ticks: assert property (
        (active_sel != $past(active_sel)) |-> $past(seen) >= 4'h4)
        else $error("switch before four current ticks");
    a_no_short: assert property (
        (active_sel != $past(active_sel)) |-> !SYS_TICK)
        else $error("system tick at switch instant");
    a_fast_on: assert property (
        (CE && mode == MODE_FAST) |=> FAST_OSC_RUN)
        else $error("fast oscillator off in fast mode");
    a_cpu_state: assert property (
        CE |=> CPU_RUN == scmc_is_run($past(mode)))
        else $error("cpu run flag disagrees with mode");

endmodule

// file: bench/scmc_top_tb.sv
// self-checking testbench for the system clock mode control block
`timescale 1ns/1ps
module scmc_top_tb;
    import scmc_pkg::*;

    // ----------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------
    logic                  MCLK          = 1'b0;
    logic                  CE            = 1'b1;
    logic                  RESETN        = 1'b0;
    logic [SEL_W-1:0]      SYSCLK_SELECT = SEL_RESET;
    logic                  HALT_FAST_OSC_KEEP = 1'b0;
    logic                  HALT_SLOW_OSC_KEEP = 1'b0;
    logic                  FAST_OSC_ENABLE    = 1'b1;
    logic                  WATCHDOG_TIMER_ENABLE = 1'b0;
    logic                  HALT_REQ      = 1'b0;
    logic                  WAKE_REQ      = 1'b0;
    logic                  SLOW_OSC_TICK = 1'b0;
    logic [2:0]            slow_cnt      = 3'h0;
    logic                  FAST_OSC_RUN;
    logic                  SLOW_OSC_RUN;
    logic                  SYS_TICK;
    logic [DIV_STAGES:0]   FAST_DIV_TICK;
    logic                  SUB_CLK_TICK;
    logic                  SLOW_RC_OSC_TICK;
    logic                  CPU_RUN;
    scmc_mode_t            MODE;
    logic [SEL_W-1:0]      ACTIVE_SELECT;
    logic                  SWITCH_BUSY;
    int                    failures  = 0;
    int                    tests_run = 0;
    logic [7:0]            per;
    logic [2:0]            seen;
    logic [7:0]            taps_seen;
    int                    t0;
    int                    elapsed;
    int                    cyc = 0;

    // keep_f keep_s watchdog | mode | fast slow | sys sub slow_osc
    // rows 5 and 6 are taken with the sub clock as system clock
    localparam logic [10:0] HALT_TAB [7] = '{
        {3'b000, MODE_SLEEP, 2'b00, 3'b000},
        {3'b001, MODE_SLEEP, 2'b01, 3'b001},
        {3'b010, MODE_IDLE0, 2'b01, 3'b011},
        {3'b110, MODE_IDLE1, 2'b11, 3'b111},
        {3'b101, MODE_IDLE2, 2'b11, 3'b101},
        {3'b010, MODE_IDLE0, 2'b01, 3'b111},
        {3'b100, MODE_IDLE2, 2'b11, 3'b001}};

    scmc_top i_dut
    (
        .MCLK               (MCLK),
        .RESETN             (RESETN),
        .CE                 (CE),
        .SYSCLK_SELECT      (SYSCLK_SELECT),
        .HALT_FAST_OSC_KEEP (HALT_FAST_OSC_KEEP),
        .HALT_SLOW_OSC_KEEP (HALT_SLOW_OSC_KEEP),
        .FAST_OSC_ENABLE    (FAST_OSC_ENABLE),
        .WATCHDOG_TIMER_ENABLE (WATCHDOG_TIMER_ENABLE),
        .HALT_REQ           (HALT_REQ),
        .WAKE_REQ           (WAKE_REQ),
        .FAST_OSC_TICK      (1'b1),
        .SLOW_OSC_TICK      (SLOW_OSC_TICK),
        .FAST_OSC_RUN       (FAST_OSC_RUN),
        .SLOW_OSC_RUN       (SLOW_OSC_RUN),
        .SYS_TICK           (SYS_TICK),
        .FAST_DIV_TICK      (FAST_DIV_TICK),
        .SUB_CLK_TICK       (SUB_CLK_TICK),
        .SLOW_RC_OSC_TICK   (SLOW_RC_OSC_TICK),
        .CPU_RUN            (CPU_RUN),
        .MODE               (MODE),
        .ACTIVE_SELECT      (ACTIVE_SELECT),
        .SWITCH_BUSY        (SWITCH_BUSY)
    );

    // ----------------------------------------------------------
    // clock and oscillator models
    // ----------------------------------------------------------
    always #50 MCLK = ~MCLK;

    // fast oscillator ticks every cycle, slow one every 8th cycle
    always @(posedge MCLK)
    begin
        slow_cnt      <= slow_cnt + 3'h1;
        SLOW_OSC_TICK <= (slow_cnt == 3'h7);
        cyc           <= cyc + 1;
    end

    // ----------------------------------------------------------
    // helper tasks
    // ----------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // cycles between two system ticks; bounded wait for the first
    task automatic sys_period(output logic [7:0] p);
        int n;
        n = 0;
        @(posedge MCLK);
        while (SYS_TICK !== 1'b1 && n < 300)
        begin
            @(posedge MCLK);
            n++;
        end
        p = 8'h0;
        do
        begin
            @(posedge MCLK);
            p++;
        end
        while (SYS_TICK !== 1'b1 && p < 8'hFF);
    endtask

    // change select, check busy, delay bounds and new tick period
    task automatic switch_to(input logic [2:0] sel, input int oldp,
                             input logic [7:0] newp);
        int n;
        @(posedge MCLK);
        SYSCLK_SELECT <= sel;
        t0 = cyc;
        n = 0;
        while (SWITCH_BUSY !== 1'b1 && n < 6)
        begin
            @(posedge MCLK);
            n++;
        end
        chk("switch busy", 8'h1, {7'h0, SWITCH_BUSY});
        while (ACTIVE_SELECT !== sel && n < 800)
        begin
            @(posedge MCLK);
            n++;
        end
        elapsed = cyc - t0;
        chk("active select", {5'h0, sel}, {5'h0, ACTIVE_SELECT});
        chk("delay min", 8'h1, {7'h0, elapsed >= 4 * oldp});
        chk("delay max", 8'h1,
            {7'h0, elapsed <= 6 * oldp + int'(newp) + 6});
        repeat (3) @(posedge MCLK);
        chk("busy cleared", 8'h0, {7'h0, SWITCH_BUSY});
        sys_period(per);
        chk("sys period", newp, per);
    endtask

    // which of system, sub and slow ticks appear over 40 cycles
    task automatic count_ticks(output logic [2:0] s);
        s = 3'h0;
        repeat (40)
        begin
            @(posedge MCLK);
            s = s | {SYS_TICK, SUB_CLK_TICK, SLOW_RC_OSC_TICK};
        end
    endtask

    // ticks seen on one divider tap over 128 cycles
    task automatic div_count(input int k, output logic [7:0] c);
        c = 8'h0;
        repeat (128)
        begin
            @(posedge MCLK);
            c = c + {7'h0, FAST_DIV_TICK[k]};
        end
    endtask

    // halt with one row's keep and watchdog settings, check, then wake
    task automatic halt_row(input logic [10:0] r, input scmc_mode_t wm);
        HALT_FAST_OSC_KEEP    <= r[10];
        HALT_SLOW_OSC_KEEP    <= r[9];
        WATCHDOG_TIMER_ENABLE <= r[8];
        @(posedge MCLK);
        HALT_REQ <= 1'b1;
        @(posedge MCLK);
        HALT_REQ <= 1'b0;
        repeat (4) @(posedge MCLK);
        chk("halt mode", {5'h0, r[7:5]}, {5'h0, MODE});
        chk("halt cpu", 8'h0, {7'h0, CPU_RUN});
        chk("halt osc", {6'h0, r[4:3]},
            {6'h0, FAST_OSC_RUN, SLOW_OSC_RUN});
        count_ticks(seen);
        chk("halt ticks", {5'h0, r[2:0]},
            {5'h0, seen});
        WAKE_REQ <= 1'b1;
        @(posedge MCLK);
        WAKE_REQ <= 1'b0;
        repeat (4) @(posedge MCLK);
        chk("wake mode", {5'h0, wm}, {5'h0, MODE});
        chk("wake cpu", 8'h1, {7'h0, CPU_RUN});
    endtask

    task automatic final_report;
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------------------------
    // watchdog: the whole sequence needs well under 10000 cycles
    // ----------------------------------------------------------
    initial
    begin
        #3_000_000;
        failures++;
        final_report();
    end

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge MCLK);
        RESETN <= 1'b1;
        repeat (2) @(posedge MCLK);
        chk("reset mode", {5'h0, MODE_FAST}, {5'h0, MODE});
        chk("reset run", 8'h7,
            {5'h0, CPU_RUN, FAST_OSC_RUN, SLOW_OSC_RUN});
        chk("reset select", 8'h0, {5'h0, ACTIVE_SELECT});
        // each divider tap fires once every 2**k fast ticks
        for (int k = 0; k <= DIV_STAGES; k++)
        begin
            div_count(k, taps_seen);
            chk("divider tap", 8'(128 >> k), taps_seen);
        end
        // every divide ratio, from fast/1 upwards, then back to 1
        for (int s = 1; s < 7; s++)
            switch_to(3'(s), 1 << (s - 1), 8'(1 << s));
        switch_to(3'h0, 64, 8'h1);
        // sub clock: slow mode keeps the cpu running
        switch_to(SEL_SLOW, 1, 8'h8);
        chk("slow mode", {5'h0, MODE_SLOW}, {5'h0, MODE});
        chk("slow cpu", 8'h1, {7'h0, CPU_RUN});
        FAST_OSC_ENABLE <= 1'b0;
        repeat (4) @(posedge MCLK);
        chk("fast off", 8'h0, {7'h0, FAST_OSC_RUN});
        FAST_OSC_ENABLE <= 1'b1;
        repeat (4) @(posedge MCLK);
        chk("fast on", 8'h1, {7'h0, FAST_OSC_RUN});
        switch_to(3'h0, 8, 8'h1);
        // a wake event while running is ignored
        WAKE_REQ <= 1'b1;
        @(posedge MCLK);
        WAKE_REQ <= 1'b0;
        repeat (3) @(posedge MCLK);
        chk("wake ignored", {5'h0, MODE_FAST}, {5'h0, MODE});
        // every halt mode, entered from fast/1 and left by wake
        for (int i = 0; i < 5; i++)
            halt_row(HALT_TAB[i], MODE_FAST);
        // idle0 and idle2 again with the sub clock as system clock
        switch_to(SEL_SLOW, 1, 8'h8);
        for (int i = 5; i < 7; i++)
            halt_row(HALT_TAB[i], MODE_SLOW);
        // freeze: a select change made while CE is low is not taken
        @(posedge MCLK);
        CE            <= 1'b0;
        SYSCLK_SELECT <= 3'h3;
        repeat (20) @(posedge MCLK);
        chk("frozen busy", 8'h0, {7'h0, SWITCH_BUSY});
        chk("frozen select", {5'h0, SEL_SLOW}, {5'h0, ACTIVE_SELECT});
        SYSCLK_SELECT <= SEL_SLOW;
        @(posedge MCLK);
        CE <= 1'b1;
        repeat (4) @(posedge MCLK);
        chk("thawed busy", 8'h0, {7'h0, SWITCH_BUSY});
        chk("thawed mode", {5'h0, MODE_SLOW}, {5'h0, MODE});
        final_report();
    end
endmodule
